// file: common/csc_link_if.sv
`default_nettype none
interface csc_link_if;
	logic s_clock;
	logic s_data;
	logic s_load;
	logic p_load;
	logic oe;
	logic [8:0] m_val;
	logic m_drv;
	logic [1:0] n_val;
	logic n_drv;
	logic [8:0] m_pin;
	logic [1:0] n_pin;
	logic fout;
	logic fout_n;
	logic test;
	// pull-ups on the parallel pins when nobody drives them
	assign m_pin = m_drv ? m_val : 9'h1ff; // see [RULE13]
	assign n_pin = n_drv ? n_val : 2'h3; // see [RULE13]
	modport host (output s_clock, s_data, s_load, p_load, oe, m_val, m_drv,
		n_val, n_drv, input fout, fout_n, test);
	modport dev (input s_clock, s_data, s_load, p_load, oe, m_pin, n_pin,
		output fout, fout_n, test);
endinterface
`default_nettype wire

// file: common/csc_pkg.sv
// Contract
// [RULE1] reference divided by sixteen before comparator
// [RULE2] vco runs at four times M times reference
// [RULE3] controller keeps vco in 800..1600 MHz; host loads any M, lock_ok only flags the range
// [RULE4] M loaded only via serial or parallel
// [RULE5] post-divider ratios 1, 2, 4 or 8
// [RULE6] N codes 00,01,10,11 give 1,2,4,8
// [RULE7] output clock has 50 percent duty
// [RULE8] parallel path takes M[8:0] and N[1:0]
// [RULE9] latches follow parallel while strobe low
// [RULE10] parallel inputs stable across strobe rise
// [RULE11] hold parallel strobe low during reset
// [RULE12] parallel path beats serial path
// [RULE13] undriven M and N read as one
// [RULE14] serial shift register is fourteen bits
// [RULE15] one shift per serial clock rise
// [RULE16] serial strobe fall captures shift register
// [RULE17] transparent while serial strobe high; hold data
// [RULE18] test output chosen by 3-bit selector
// [RULE19] controller picks inactive test selection; WORD_RST holds T code 3 (T_OUT)
// [RULE20] output gate synchronised, no runt pulses
// [RULE21] gated off: true low, complement high
// [RULE22] word is T, N, M, MSB first
// [RULE23] fout = xtal/16 * 4M / ratio
`default_nettype none
package csc_pkg;
	localparam int M_W = 9;
	localparam int N_W = 2;
	localparam int T_W = 3;
	localparam int WORD_W = 14;
	// serial word layout, most significant bit shifted first
	localparam int WORD_M_LSB = 0;
	localparam int WORD_N_LSB = 9;
	localparam int WORD_T_LSB = 11;
	localparam int REF_DIV = 16;
	localparam int VCO_MULT = 4;
	localparam int VCO_MIN_KHZ = 800_000;
	localparam int VCO_MAX_KHZ = 1_600_000;
	localparam int XTAL_KHZ = 16_000;
	localparam logic [M_W-1:0] M_RST = 9'h1ff;
	localparam logic [N_W-1:0] N_RST = 2'h3;
	localparam logic [T_W-1:0] T_RST = 3'h0;
	// test selector codes
	localparam logic [T_W-1:0] T_OFF = 3'h0;
	localparam logic [T_W-1:0] T_REF = 3'h1;
	localparam logic [T_W-1:0] T_VCO = 3'h2;
	localparam logic [T_W-1:0] T_OUT = 3'h3;
	localparam logic [T_W-1:0] T_HIGH = 3'h4;
	// host timing: serial half period
	localparam int PCLK_MHZ = 50;
	localparam int HALF_NS = 100;
	localparam int HALF_CYC = (HALF_NS * PCLK_MHZ + 999) / 1000;
	// host registers, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_WORD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CTRL_SER = 0;
	localparam int CTRL_PAR = 1;
	localparam int CTRL_OE = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_CNT_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0004;
	localparam logic [31:0] WORD_RST = 32'h0000_1fff;

	function automatic logic [3:0] post_ratio(input logic [N_W-1:0] n);
		post_ratio = 4'h1 << n; // see [RULE6]
	endfunction
endpackage
`default_nettype wire

// file: dv/clock_synth_config_bench.sv
`default_nettype none
`define CHK(what, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) begin \
			bad_count++; \
			$display("wrong value %s exp %h seen %h", what, ex, got); \
		end \
	end
module clock_synth_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import csc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lock_ok, er;
	logic [31:0] paddr, pwdata, prdata, vco_khz, fout_khz, rd, s0;
	logic [8:0] cfg_m, m;
	logic [1:0] cfg_n, n;
	logic [2:0] cfg_t, t;
	logic [10:0] vco_mult;
	logic [8:0] edge_m [4] = '{9'h0c7, 9'h0c8, 9'h190, 9'h191};
	int bad_count, checks_done, seed;
	csc_link_if link_i();
	csc_dev csc_dev_i (.pclk, .presetn, .link(link_i), .cfg_m, .cfg_n,
		.cfg_t, .vco_mult, .vco_khz, .fout_khz, .lock_ok);
	csc_host csc_host_i (.pclk, .presetn, .link(link_i), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	csc_chk csc_chk_i (.pclk, .presetn, .s_clock(link_i.s_clock),
		.s_data(link_i.s_data), .s_load(link_i.s_load),
		.p_load(link_i.p_load), .oe(link_i.oe), .n_pin(link_i.n_pin),
		.fout(link_i.fout), .fout_n(link_i.fout_n), .test(link_i.test));
	function automatic logic [31:0] exp_vco(input logic [8:0] em);
		exp_vco = 32'(XTAL_KHZ / REF_DIV * VCO_MULT) * {23'h00_0000, em};
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {24'h00_0000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic load(input logic [1:0] go, input logic [2:0] lt);
		apb(1'b1, REG_WORD, {18'h0_0000, lt, n, m});
		apb(1'b1, REG_CTRL, {30'h0000_0001, go});
		rd = 32'h0000_0001;
		while (rd[STAT_BUSY] !== 1'b0)
			apb(1'b0, REG_STAT, 32'h0000_0000);
		// device resyncs its pins a few cycles after the host goes idle
		repeat (12) @(posedge pclk);
	endtask
	task automatic check_cfg(input logic [2:0] et);
		logic [31:0] v;
		logic lk;
		int hi;
		v = exp_vco(m);
		lk = v >= VCO_MIN_KHZ && v <= VCO_MAX_KHZ;
		hi = 0;
		`CHK("cfg_m", m, cfg_m)
		`CHK("cfg_n", n, cfg_n)
		`CHK("cfg_t", et, cfg_t)
		`CHK("vco_mult", 11'(m) * 11'h004, vco_mult)
		`CHK("vco_khz", v, vco_khz)
		`CHK("fout_khz", v >> n, fout_khz)
		`CHK("lock_ok", lk, lock_ok)
		for (int i = 0; i < 40 && link_i.fout !== 1'b0; i++)
			@(posedge pclk);
		for (int i = 0; i < 40 && link_i.fout !== 1'b1; i++)
			@(posedge pclk);
		while (link_i.fout === 1'b1 && hi < 40) begin
			@(posedge pclk);
			hi++;
		end
		`CHK("high run", 32'h0000_0001 << n, hi)
	endtask
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		repeat (30000) @(posedge pclk);
		bad_count++;
		complete_run();
	end
	initial begin
		seed = 32'h6343_d7b4;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (40) @(posedge pclk);
		m = M_RST;
		n = N_RST;
		check_cfg(T_RST);
		`CHK("m idle", {M_W{1'b1}}, link_i.m_pin)
		`CHK("n idle", {N_W{1'b1}}, link_i.n_pin)
		apb(1'b0, REG_CTRL, 32'h0000_0000);
		`CHK("ctrl", CTRL_RST, rd)
		apb(1'b0, REG_WORD, 32'h0000_0000);
		`CHK("word", WORD_RST, rd)
		apb(1'b1, 8'h0c, 32'hffff_ffff);
		`CHK("unmapped err", 1'b1, er)
		apb(1'b0, REG_STAT, 32'h0000_0000);
		s0 = rd;
		$display("test reset done");
		// lock limits first, then random M values; N steps through its four codes
		for (int i = 0; i < 8; i++) begin
			m = i < 4 ? edge_m[i] : 9'($random(seed));
			n = 2'(i);
			load(2'h2, 3'($random(seed)));
			check_cfg(T_RST);
		end
		$display("test parallel done");
		for (int i = 0; i < 8; i++) begin
			// finish on T_OFF so the test pin stays quiet
			t = i < 3 ? 3'($random(seed)) : 3'(7 - i);
			n = 2'($random(seed));
			m = 9'($random(seed));
			load(2'h1, t);
			check_cfg(t);
			if (t == T_HIGH || t == T_OFF)
				`CHK("test pin", t == T_HIGH, link_i.test)
		end
		apb(1'b0, REG_STAT, 32'h0000_0000);
		`CHK("load count", s0[23:8] + 16'h0010, rd[23:8])
		$display("test serial done");
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		repeat (30) @(posedge pclk);
		`CHK("fout off", 1'b0, link_i.fout)
		`CHK("fout_n off", 1'b1, link_i.fout_n)
		apb(1'b1, REG_CTRL, 32'h0000_0004);
		check_cfg(T_OFF);
		$display("test gate done");
		complete_run();
	end
endmodule
`default_nettype wire

// file: dv/csc_chk.sv
`default_nettype none
module csc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic s_clock,
	input wire logic s_data,
	input wire logic s_load,
	input wire logic p_load,
	input wire logic oe,
	input wire logic [1:0] n_pin,
	input wire logic fout,
	input wire logic fout_n,
	input wire logic test
);
	import csc_pkg::*;
	logic [7:0] hi_q, lo_q, oel_q, oeh_q, set_q;
	logic [13:0] sh_q;
	logic [1:0] en_q;
	logic [2:0] et_q;
	logic sck_q, sld_q, keep;
	function automatic logic [7:0] bump(input logic [7:0] c, input logic on);
		bump = on ? c + {7'h00, c != 8'hff} : 8'h00;
	endfunction
	// settle count restarts on a serial strobe or on an N change the device has yet to resync
	assign keep = !s_load && !sld_q && (p_load || n_pin == en_q);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 8'h00;
			lo_q <= 8'h00;
			oel_q <= 8'h00;
			oeh_q <= 8'h00;
			set_q <= 8'h00;
		end else begin
			hi_q <= bump(hi_q, fout);
			lo_q <= bump(lo_q, !fout);
			oel_q <= bump(oel_q, !oe);
			oeh_q <= bump(oeh_q, oe);
			set_q <= bump(set_q, keep);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_q <= 14'h0000;
			sck_q <= 1'b0;
			sld_q <= 1'b0;
			en_q <= N_RST;
			et_q <= T_RST;
		end else begin
			sck_q <= s_clock;
			sld_q <= s_load;
			if (s_clock && !sck_q)
				sh_q <= {sh_q[12:0], s_data};
			if (!p_load)
				en_q <= n_pin;
			else if (sld_q && !s_load) begin
				en_q <= sh_q[WORD_N_LSB +: N_W];
				et_q <= sh_q[WORD_T_LSB +: T_W];
			end
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	pair_compl_a:
		assert property (fout_n == !fout) else $error("fout_n not inverse");
	gate_park_a:
		assert property (oel_q > 8'h14 |-> !fout && fout_n)
		else $error("output not parked while gated");
	no_runt_a:
		assert property ($fell(fout) |-> hi_q inside {8'h01, 8'h02, 8'h04, 8'h08})
		else $error("runt high pulse");
	high_ratio_a:
		assert property ($fell(fout) && set_q > 8'h28 && oeh_q > 8'h28
			|-> hi_q == 8'h01 << en_q) else $error("high run off ratio");
	low_ratio_a:
		assert property ($rose(fout) && set_q > 8'h28 && oeh_q > 8'h28
			|-> lo_q == 8'h01 << en_q) else $error("low run off ratio");
	gate_hold_a:
		assert property ($rose(fout) |-> oel_q < 8'h08)
		else $error("output started while gated");
	test_high_a:
		assert property (set_q > 8'h28 && et_q == T_HIGH |-> test)
		else $error("test pin not high");
	test_low_a:
		assert property (set_q > 8'h28 && et_q == T_OFF |-> !test)
		else $error("test pin not low");
	cover property ($fell(fout) && hi_q == 8'h08);
	cover property ($fell(s_load) && p_load);
	cover property (oel_q == 8'h20);
endmodule
`default_nettype wire

// file: hw/csc_dev.sv
// The register addresses and register access over APB were decided locally.
`default_nettype none
module csc_dev #(
	parameter int XTAL_KHZ_P = csc_pkg::XTAL_KHZ
) (
	input wire logic pclk,
	input wire logic presetn,
	csc_link_if.dev link,
	output logic [csc_pkg::M_W-1:0] cfg_m,
	output logic [csc_pkg::N_W-1:0] cfg_n,
	output logic [csc_pkg::T_W-1:0] cfg_t,
	output logic [10:0] vco_mult,
	output logic [31:0] vco_khz,
	output logic [31:0] fout_khz,
	output logic lock_ok
);
	import csc_pkg::*;

	localparam int PIN_W = 16;
	localparam int P_M = 0;
	localparam int P_N = 9;
	localparam int P_SCLK = 11;
	localparam int P_SDAT = 12;
	localparam int P_SLD = 13;
	localparam int P_PLD = 14;
	localparam int P_OE = 15;
	// pins idle as their pulled or strapped levels
	localparam logic [PIN_W-1:0] PIN_RST = 16'hc7ff; // see [RULE13]

	logic [PIN_W-1:0] pin_w;
	logic [PIN_W-1:0] s1_q, s2_q, s3_q, pin_q;
	logic sclk_prev_q;
	logic [WORD_W-1:0] sr_q;
	logic [M_W-1:0] m_q;
	logic [N_W-1:0] n_q;
	logic [T_W-1:0] t_q;
	logic [3:0] ref_cnt_q;
	logic ref_clk_q;
	logic vco_clk_q;
	logic [3:0] post_cnt_q;
	logic [N_W-1:0] div_n_q;
	logic raw_q;
	logic gate_q;
	logic fout_q, fout_n_q, test_q;
	logic [10:0] vco_mult_q;
	logic [31:0] vco_khz_q, fout_khz_q;
	logic lock_ok_q;
	logic [3:0] ratio_w;
	logic [31:0] vco_khz_d;

	assign pin_w = {link.oe, link.p_load, link.s_load, link.s_data,
		link.s_clock, link.n_pin, link.m_pin};

	// three-stage synchroniser; a bit counts once stages 2 and 3 agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= PIN_RST;
			s2_q <= PIN_RST;
			s3_q <= PIN_RST;
		end else begin
			s1_q <= pin_w;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= PIN_RST;
		end else begin
			for (int i = 0; i < PIN_W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					pin_q[i] <= s3_q[i];
				end
			end
		end
	end

	// serial shift register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_prev_q <= 1'b0;
			sr_q <= '0;
		end else begin
			sclk_prev_q <= pin_q[P_SCLK];
			if (pin_q[P_SCLK] && !sclk_prev_q) begin // see [RULE15]
				sr_q <= {sr_q[WORD_W-2:0], pin_q[P_SDAT]}; // see [RULE14]
			end
		end
	end

	// configuration latches; modelled as transparent latches on pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_q <= M_RST;
			n_q <= N_RST;
			t_q <= T_RST;
		end else if (!pin_q[P_PLD]) begin // see [RULE9] [RULE12]
			// parallel path follows pins, holds after strobe rise
			m_q <= pin_q[P_M +: M_W]; // see [RULE8]
			n_q <= pin_q[P_N +: N_W]; // see [RULE8]
		end else if (pin_q[P_SLD]) begin // see [RULE17]
			// held value after strobe fall is the capture
			m_q <= sr_q[WORD_M_LSB +: M_W]; // see [RULE16] [RULE22]
			n_q <= sr_q[WORD_N_LSB +: N_W]; // see [RULE22]
			t_q <= sr_q[WORD_T_LSB +: T_W]; // see [RULE18] [RULE22]
		end
	end

	// reference pre-divider, one toggle per half of sixteen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cnt_q <= '0;
			ref_clk_q <= 1'b0;
		end else begin
			ref_cnt_q <= ref_cnt_q + 4'h1;
			if (ref_cnt_q == 4'(REF_DIV / 2 - 1) ||
					ref_cnt_q == 4'(REF_DIV - 1)) begin // see [RULE1]
				ref_clk_q <= ~ref_clk_q;
			end
		end
	end

	// digital stand-in for the vco: half of pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vco_clk_q <= 1'b0;
		end else begin
			vco_clk_q <= ~vco_clk_q;
		end
	end

	assign ratio_w = post_ratio(div_n_q); // see [RULE5] [RULE6]

	// toggling at the terminal count keeps both halves equal
	// a new ratio waits for the next toggle; a cut half would be a runt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_cnt_q <= '0;
			raw_q <= 1'b0;
			div_n_q <= N_RST;
		end else if (post_cnt_q >= ratio_w - 4'h1) begin
			post_cnt_q <= '0;
			raw_q <= ~raw_q; // see [RULE7]
			div_n_q <= n_q; // see [RULE7]
		end else begin
			post_cnt_q <= post_cnt_q + 4'h1;
		end
	end

	// gate only moves while the raw clock is low, so no runts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= 1'b0;
		end else if (!raw_q) begin
			gate_q <= pin_q[P_OE]; // see [RULE20]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fout_q <= 1'b0;
			fout_n_q <= 1'b1;
		end else begin
			fout_q <= raw_q & gate_q; // see [RULE21]
			fout_n_q <= ~(raw_q & gate_q); // see [RULE21]
		end
	end

	// diagnostic mux; the off code keeps the pin quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_q <= 1'b0;
		end else begin
			unique case (t_q) // see [RULE18]
				T_OFF: test_q <= 1'b0;
				T_REF: test_q <= ref_clk_q;
				T_VCO: test_q <= vco_clk_q;
				T_OUT: test_q <= raw_q;
				T_HIGH: test_q <= 1'b1;
				default: test_q <= 1'b0;
			endcase
		end
	end

	// frequency bookkeeping; loop locks only inside the vco range
	assign vco_khz_d = (32'(XTAL_KHZ_P) / 32'(REF_DIV)) *
		32'(VCO_MULT) * 32'(m_q); // see [RULE2]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vco_mult_q <= '0;
			vco_khz_q <= '0;
			fout_khz_q <= '0;
			lock_ok_q <= 1'b0;
		end else begin
			vco_mult_q <= 11'(VCO_MULT) * 11'(m_q); // see [RULE2]
			vco_khz_q <= vco_khz_d;
			fout_khz_q <= vco_khz_d >> n_q; // see [RULE23]
			lock_ok_q <= vco_khz_d >= 32'(VCO_MIN_KHZ) &&
				vco_khz_d <= 32'(VCO_MAX_KHZ); // see [RULE3]
		end
	end

	assign link.fout = fout_q;
	assign link.fout_n = fout_n_q;
	assign link.test = test_q;
	assign cfg_m = m_q;
	assign cfg_n = n_q;
	assign cfg_t = t_q;
	assign vco_mult = vco_mult_q;
	assign vco_khz = vco_khz_q;
	assign fout_khz = fout_khz_q;
	assign lock_ok = lock_ok_q;
endmodule
`default_nettype wire

// file: hw/csc_host.sv
`default_nettype none
module csc_host #(
	parameter int HALF_CYC_P = csc_pkg::HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	csc_link_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import csc_pkg::*;

	typedef enum {
		ST_INIT, ST_IDLE, ST_SH_LO, ST_SH_HI, ST_LD_HI, ST_LD_LO,
		ST_PAR_SET, ST_PAR_HI
	} csc_state_t;

	csc_state_t st_q;
	logic [7:0] tick_cnt_q;
	logic tick_q;
	logic [31:0] ctrl_q, word_q;
	logic [WORD_W-1:0] sh_q;
	logic [4:0] bits_q;
	logic [15:0] done_cnt_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic sclk_q, sdat_q, sld_q, pld_q, drv_q;
	logic wr_w, busy_w, mapped_w;

	assign busy_w = st_q != ST_IDLE;
	assign mapped_w = paddr[7:0] == REG_CTRL || paddr[7:0] == REG_WORD ||
		paddr[7:0] == REG_STAT;
	assign wr_w = psel && penable && pready_q && pwrite && mapped_w;

	// no wait states: answer prepared in setup, taken in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else if (psel && !penable && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= !mapped_w;
			unique case (paddr[7:0])
				REG_CTRL: prdata_q <= ctrl_q;
				REG_WORD: prdata_q <= word_q;
				REG_STAT: prdata_q <= {8'h00, done_cnt_q, 7'h00, busy_w};
				default: prdata_q <= '0;
			endcase
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			word_q <= WORD_RST;
		end else if (wr_w && paddr[7:0] == REG_CTRL) begin
			ctrl_q <= 32'(pwdata[CTRL_OE]) << CTRL_OE;
		end else if (wr_w && paddr[7:0] == REG_WORD) begin
			word_q <= 32'(pwdata[WORD_W-1:0]);
		end
	end

	// pin rate enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q >= 8'(HALF_CYC_P - 1)) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 8'h01;
			tick_q <= 1'b0;
		end
	end

	// strobe low from reset until the power-up parallel load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_INIT;
			sclk_q <= 1'b0;
			sdat_q <= 1'b0;
			sld_q <= 1'b0;
			pld_q <= 1'b0; // see [RULE11]
			drv_q <= 1'b0;
			sh_q <= '0;
			bits_q <= '0;
			done_cnt_q <= '0;
		end else begin
			unique case (st_q)
				ST_INIT: if (tick_q) begin
					drv_q <= 1'b1;
					st_q <= ST_PAR_SET;
				end
				ST_IDLE: if (wr_w && paddr[7:0] == REG_CTRL &&
						pwdata[CTRL_PAR]) begin
					// strobe drops one to five cycles before the pins move, so
					// the device's resync never drops a short low
					pld_q <= 1'b0;
					st_q <= ST_INIT;
				end else if (wr_w && paddr[7:0] == REG_CTRL &&
						pwdata[CTRL_SER]) begin
					sh_q <= word_q[WORD_W-1:0]; // see [RULE22]
					bits_q <= 5'(WORD_W);
					st_q <= ST_SH_LO;
				end
				ST_SH_LO: if (tick_q) begin
					sclk_q <= 1'b0;
					sdat_q <= sh_q[WORD_W-1];
					sh_q <= {sh_q[WORD_W-2:0], 1'b0};
					bits_q <= bits_q - 5'h01;
					st_q <= ST_SH_HI;
				end
				ST_SH_HI: if (tick_q) begin
					sclk_q <= 1'b1; // see [RULE15]
					st_q <= bits_q == '0 ? ST_LD_HI : ST_SH_LO;
				end
				ST_LD_HI: if (tick_q) begin
					sclk_q <= 1'b0;
					sld_q <= 1'b1;
					st_q <= ST_LD_LO;
				end
				ST_LD_LO: if (tick_q) begin
					sld_q <= 1'b0; // see [RULE16] [RULE17]
					done_cnt_q <= done_cnt_q + 16'h0001;
					st_q <= ST_IDLE;
				end
				ST_PAR_SET: if (tick_q) begin
					pld_q <= 1'b1; // see [RULE10]
					st_q <= ST_PAR_HI;
				end
				ST_PAR_HI: if (tick_q) begin
					drv_q <= 1'b0; // see [RULE10]
					done_cnt_q <= done_cnt_q + 16'h0001;
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign link.s_clock = sclk_q;
	assign link.s_data = sdat_q;
	assign link.s_load = sld_q;
	assign link.p_load = pld_q;
	assign link.oe = ctrl_q[CTRL_OE];
	assign link.m_val = word_q[WORD_M_LSB +: M_W]; // see [RULE4] [RULE8]
	assign link.n_val = word_q[WORD_N_LSB +: N_W];
	assign link.m_drv = drv_q;
	assign link.n_drv = drv_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule
`default_nettype wire
